// ==== logic/tw_dev.sv ====
// Memory end: two-wire slave with 128 byte array and timed programming
`include "tw_params.svh"
module tw_dev
   import tw_pkg::*;
#(
   parameter int PROG_CYC = `TW_PROG_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   tw_if.dev link,
   output logic busy,
   output logic standby
);
   // ****************************************
   // Pin sampling
   // ****************************************
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_q;
   logic sda_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], link.scl};
         sda_sync_q <= {sda_sync_q[0], link.sda};
         scl_q <= scl_sync_q[1];
         sda_q <= sda_sync_q[1];
      end
   end
   wire logic scl_s = scl_sync_q[1];
   wire logic sda_s = sda_sync_q[1];
   wire logic scl_rise = scl_s && !scl_q;
   wire logic scl_fall = !scl_s && scl_q;
   wire logic start_ev = scl_s && scl_q && sda_q && !sda_s;
   wire logic stop_ev = scl_s && scl_q && !sda_q && sda_s;

   // ****************************************
   // Protocol engine
   // ****************************************
   logic [7:0] mem [`TW_DEPTH];
   tw_dev_st_t st_q;
   tw_dev_st_t st_d;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [6:0] addr_q;
   logic rd_q;
   logic wrote_q;
   logic sda_oe_q;
   logic [31:0] prog_q;
   logic busy_q;
   logic standby_q;
   wire logic prog_on = prog_q != 32'h0;
   wire logic [6:0] addr_wnext = {addr_q[6:2], addr_q[1:0] + 2'h1};
   wire logic [6:0] addr_rnext = addr_q + 7'h1;
   wire logic byte_in = scl_rise && bit_q == 4'h7;
   wire logic [7:0] word_in = {sh_q[6:0], sda_s};

   always_comb begin
      st_d = st_q;
      case (st_q)
         TW_IDLE: st_d = TW_IDLE;
         TW_ADDR: if (byte_in) st_d = TW_AACK;
         // Ack states span the whole ninth clock: bit_q 8 before the eighth clock falls, 9 after
         TW_AACK: if (scl_fall && bit_q == 4'h9) st_d = rd_q ? TW_RDAT : TW_WDAT;
         TW_WDAT: if (byte_in) st_d = TW_WACK;
         TW_WACK: if (scl_fall && bit_q == 4'h9) st_d = TW_WDAT;
         TW_RDAT: if (scl_fall && bit_q == 4'h7) st_d = TW_RACK;
         TW_RACK: begin
            if (scl_rise && sda_s) begin
               st_d = TW_IDLE;
            end else if (scl_fall) begin
               st_d = TW_RDAT;
            end
         end
         default: st_d = TW_IDLE;
      endcase
      if (stop_ev) st_d = TW_IDLE;
      if (start_ev) st_d = TW_ADDR;
      if (prog_on) st_d = TW_IDLE;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= TW_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h0;
         addr_q <= 7'h0;
         rd_q <= 1'b0;
         wrote_q <= 1'b0;
         sda_oe_q <= 1'b0;
         prog_q <= 32'h0;
         busy_q <= 1'b0;
         standby_q <= 1'b1;
      end else begin
         st_q <= st_d;
         busy_q <= prog_on;
         standby_q <= st_d == TW_IDLE && !prog_on;
         if (prog_on) begin
            prog_q <= prog_q - 32'h1;
            sda_oe_q <= 1'b0;
         end else if (stop_ev || start_ev) begin
            bit_q <= 4'h0;
            sda_oe_q <= 1'b0;
            wrote_q <= 1'b0;
            if (stop_ev && wrote_q) prog_q <= PROG_CYC[31:0];
         end else begin
            // Input bits captured on rising edges
            if (scl_rise && (st_q == TW_ADDR || st_q == TW_WDAT)) begin
               sh_q <= word_in;
               bit_q <= bit_q + 4'h1;
            end
            if (byte_in && st_q == TW_ADDR) begin
               addr_q <= word_in[7:1];
               rd_q <= word_in[0];
            end
            if (byte_in && st_q == TW_WDAT) begin
               mem[addr_q] <= word_in;
               addr_q <= addr_wnext;
               wrote_q <= 1'b1;
            end
            if (scl_fall) begin
               case (st_q)
                  TW_ADDR, TW_WDAT: begin
                     sda_oe_q <= bit_q == 4'h8;
                  end
                  TW_AACK, TW_WACK: begin
                     if (bit_q == 4'h8) begin
                        sda_oe_q <= 1'b1;
                        bit_q <= 4'h9;
                     end else begin
                        // First read bit goes out as the ack slot ends
                        bit_q <= 4'h0;
                        sda_oe_q <= st_q == TW_AACK && rd_q && !mem[addr_q][7];
                     end
                  end
                  TW_RACK: begin
                     bit_q <= 4'h0;
                     sda_oe_q <= !mem[addr_q][7];
                  end
                  TW_RDAT: begin
                     if (bit_q == 4'h7) begin
                        sda_oe_q <= 1'b0;
                        addr_q <= addr_rnext;
                     end else begin
                        sda_oe_q <= !mem[addr_q][3'h6 - bit_q[2:0]];
                     end
                     bit_q <= bit_q + 4'h1;
                  end
                  default: sda_oe_q <= 1'b0;
               endcase
            end
            if (st_q == TW_RACK && scl_rise) bit_q <= 4'h0;
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Pin is open drain: output value is always low, only enable moves
   assign link.sda_dev_o = 1'b0;
   assign link.sda_dev_oe = sda_oe_q;
   assign busy = busy_q;
   assign standby = standby_q;
endmodule

// ==== logic/tw_params.svh ====
// Timing counts and field layout for the two-wire serial memory ends
`ifndef TW_PARAMS_SVH
`define TW_PARAMS_SVH
`define TW_CLK_NS 4
`define TW_PROG_MS 10
`define TW_PROG_CYC ((`TW_PROG_MS * 1000000) / `TW_CLK_NS)
`define TW_ADDR_W 7
`define TW_DATA_W 8
`define TW_DEPTH 128
`define TW_PAGE_W 2
`define TW_SCL_HALF 12
`define TW_RECOVER_CLOCKS 9
`endif

// ==== logic/tw_pkg.sv ====
// Types shared by both ends of the two-wire serial memory link
package tw_pkg;
   typedef enum logic [2:0] {
      TW_IDLE = 3'b000,
      TW_ADDR = 3'b001,
      TW_AACK = 3'b010,
      TW_WDAT = 3'b011,
      TW_WACK = 3'b100,
      TW_RDAT = 3'b101,
      TW_RACK = 3'b110
   } tw_dev_st_t;
   typedef enum logic [2:0] {
      TC_IDLE = 3'b000,
      TC_START = 3'b001,
      TC_BIT = 3'b010,
      TC_STOP = 3'b011,
      TC_DONE = 3'b100
   } tw_ctl_st_t;
endpackage

// ==== logic/tw_if.sv ====
// Open-drain two-wire link joining controller and memory
interface tw_if;
   logic scl_o;
   logic scl_oe;
   logic sda_ctl_o;
   logic sda_ctl_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   wire scl = scl_oe ? scl_o : 1'b1;
   wire sda = !((sda_ctl_oe && !sda_ctl_o) || (sda_dev_oe && !sda_dev_o));
   modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
   modport ctl (input scl, input sda, output scl_o, output scl_oe,
      output sda_ctl_o, output sda_ctl_oe);
endinterface

// ==== logic/tw_ctl.sv ====
// Controller end: drives SCL, issues start, bytes, acks and stop
`include "tw_params.svh"
module tw_ctl
   import tw_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   tw_if.ctl link,
   input wire logic req,
   input wire logic [3:0] nbytes,
   input wire logic [7:0] wdata,
   input wire logic rd_mode,
   output logic wnext,
   output logic [7:0] rdata,
   output logic rvalid,
   output logic nack,
   output logic done
);
   // ****************************************
   // Bit engine; req names: first byte from wdata, nbytes after it
   // ****************************************
   logic [1:0] sda_sync_q;
   tw_ctl_st_t st_q;
   logic [4:0] div_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [3:0] left_q;
   logic first_q;
   logic [7:0] sh_q;
   logic scl_q;
   logic sda_q;
   logic wnext_q;
   logic rvalid_q;
   logic nack_q;
   logic done_q;
   logic [7:0] rdata_q;
   wire logic tick = div_q == 5'(`TW_SCL_HALF - 1);
   wire logic sda_in = sda_sync_q[1];
   wire logic ack_slot = bit_q == 4'h8;
   wire logic rx = !first_q && rd_mode;
   // Read acks every byte but the last, so the memory stops driving
   wire logic my_ack = rx && left_q != 4'h0;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sda_sync_q <= 2'h3;
         st_q <= TC_IDLE;
         div_q <= 5'h0;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         left_q <= 4'h0;
         first_q <= 1'b0;
         sh_q <= 8'h0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         wnext_q <= 1'b0;
         rvalid_q <= 1'b0;
         nack_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= 8'h0;
      end else begin
         sda_sync_q <= {sda_sync_q[0], link.sda};
         div_q <= tick ? 5'h0 : div_q + 5'h1;
         wnext_q <= 1'b0;
         rvalid_q <= 1'b0;
         done_q <= 1'b0;
         case (st_q)
            TC_IDLE: if (req) begin
               st_q <= TC_START;
               ph_q <= 2'h0;
               sh_q <= wdata;
               left_q <= nbytes;
               first_q <= 1'b1;
               bit_q <= 4'h0;
               nack_q <= 1'b0;
               wnext_q <= 1'b1;
            end
            TC_START: if (tick) begin
               ph_q <= ph_q + 2'h1;
               if (ph_q == 2'h0) sda_q <= 1'b0;
               if (ph_q == 2'h1) begin
                  scl_q <= 1'b0;
                  st_q <= TC_BIT;
                  ph_q <= 2'h0;
               end
            end
            TC_BIT: if (tick) begin
               ph_q <= ph_q + 2'h1;
               if (ph_q == 2'h0) begin
                  sda_q <= ack_slot ? !my_ack : (rx ? 1'b1 : sh_q[7]);
               end else if (ph_q == 2'h1) begin
                  scl_q <= 1'b1;
               end else if (ph_q == 2'h2) begin
                  if (ack_slot && !rx && sda_in) nack_q <= 1'b1;
                  if (!ack_slot) sh_q <= {sh_q[6:0], sda_in};
               end else begin
                  scl_q <= 1'b0;
                  ph_q <= 2'h0;
                  bit_q <= ack_slot ? 4'h0 : bit_q + 4'h1;
                  if (bit_q == 4'h7 && rx) begin
                     rdata_q <= sh_q;
                     rvalid_q <= 1'b1;
                  end
                  if (ack_slot) begin
                     first_q <= 1'b0;
                     if (left_q == 4'h0 || nack_q) begin
                        st_q <= TC_STOP;
                     end else begin
                        left_q <= left_q - 4'h1;
                        sh_q <= wdata;
                        wnext_q <= !rd_mode;
                     end
                  end
               end
            end
            TC_STOP: if (tick) begin
               ph_q <= ph_q + 2'h1;
               if (ph_q == 2'h0) sda_q <= 1'b0;
               if (ph_q == 2'h1) scl_q <= 1'b1;
               if (ph_q == 2'h2) begin
                  sda_q <= 1'b1;
                  st_q <= TC_DONE;
               end
            end
            TC_DONE: begin
               done_q <= 1'b1;
               st_q <= TC_IDLE;
            end
            default: st_q <= TC_IDLE;
         endcase
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign link.scl_o = scl_q;
   assign link.scl_oe = 1'b1;
   assign link.sda_ctl_o = 1'b0;
   assign link.sda_ctl_oe = !sda_q;
   assign wnext = wnext_q;
   assign rdata = rdata_q;
   assign rvalid = rvalid_q;
   assign nack = nack_q;
   assign done = done_q;
endmodule

// ==== dv/tw_chk.sv ====
// Protocol checker watching the open-drain link between controller and memory
module tw_chk
   import tw_pkg::*;
#(
   parameter int PROG_CYC = 200
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_ctl_o,
   input wire logic sda_ctl_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Bus decoding
   // ****************************************
   logic scl_q;
   logic sda_q;
   logic act_q;
   logic rw_q;
   logic [3:0] bit_q;
   logic [7:0] byte_q;
   logic [31:0] prog_q;
   // Set when a transfer began while programming could still be running
   logic ref_q;
   wire start_w = scl_q && scl && sda_q && !sda;
   wire stop_w = scl_q && scl && !sda_q && sda;
   wire rise_w = scl && !scl_q;
   wire ack_w = (byte_q == 8'h00) || !rw_q;
   wire slot_w = act_q && ((bit_q == 4'h8) ? ack_w : (byte_q != 8'h00 && rw_q));
   wire wr_end_w = stop_w && act_q && !rw_q && (byte_q >= 8'h02);
   // Bit 1 of later bytes starts from 9, so ack slots always sit at 8
   wire [3:0] bit_d = start_w ? 4'h0 :
      (rise_w ? ((bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1) : bit_q);
   wire [7:0] byte_d = start_w ? 8'h00 : ((rise_w && bit_q == 4'h8) ? byte_q + 8'h01 : byte_q);
   wire rw_d = (rise_w && bit_q == 4'h7 && byte_q == 8'h00) ? sda : rw_q;
   wire act_d = start_w ? 1'b1 : (stop_w ? 1'b0 : act_q);
   // Margin covers the device's own synchroniser delay on stop
   wire logic [31:0] prog_d = wr_end_w ? 32'(PROG_CYC + 16) :
      ((prog_q != 32'h0) ? prog_q - 32'h1 : 32'h0);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         act_q <= 1'b0;
         rw_q <= 1'b0;
         bit_q <= 4'h0;
         byte_q <= 8'h00;
         prog_q <= 32'h0;
         ref_q <= 1'b0;
      end else begin
         ref_q <= start_w ? (prog_q != 32'h0) : ref_q;
         scl_q <= scl;
         sda_q <= sda;
         act_q <= act_d;
         rw_q <= rw_d;
         bit_q <= bit_d;
         byte_q <= byte_d;
         prog_q <= prog_d;
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   a_dev_low_only: assert property (sda_dev_oe |-> !sda_dev_o)
      else $error("memory end drove data high");
   a_ctl_low_only: assert property (sda_ctl_oe |-> !sda_ctl_o)
      else $error("controller drove data high");
   a_dev_scl_low: assert property ($changed(sda_dev_oe) |-> !scl && !scl_q)
      else $error("memory end changed data with clock high");
   a_dev_hold_high: assert property ($rose(scl) |-> $stable(sda_dev_oe) [*8])
      else $error("memory end data moved in clock high phase");
   a_ctl_data_stable: assert property (act_q && scl && scl_q && bit_q >= 4'h2 && !stop_w
      |-> $stable(sda))
      else $error("data moved mid-byte with clock high");
   a_quiet_idle: assert property (!act_q |-> !sda_dev_oe)
      else $error("memory end drove data outside a transfer");
   a_dev_slot: assert property (rise_w && sda_dev_oe |-> slot_w)
      else $error("memory end drove data outside its slots");
   a_addr_ack: assert property (rise_w && act_q && bit_q == 4'h8 && ack_w && !ref_q
      |-> sda_dev_oe)
      else $error("memory end missed an acknowledge");
   a_prog_quiet: assert property (prog_q > 32'h10 |-> !sda_dev_oe)
      else $error("memory end answered while programming");
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench joining both ends of the two-wire memory link
module tb_top
   import tw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Programming long enough that an immediate follow-up is refused
   localparam int PROG = 2000;
   logic clk;
   logic nrst;
   logic req;
   logic [3:0] nbytes;
   logic [7:0] wdata;
   logic rd_mode;
   logic wnext;
   logic [7:0] rdata;
   logic rvalid;
   logic nack;
   logic done;
   logic busy;
   logic standby;
   logic [31:0] rng_q;
   logic [7:0] mem [128];
   int mismatches;
   int samples_checked;
   int j;
   logic [6:0] ra;
   int rn;
   tw_if tw_if_i();
   tw_dev #(.PROG_CYC(PROG)) tw_dev_i(.clk(clk), .nrst(nrst), .link(tw_if_i), .busy(busy),
      .standby(standby));
   tw_ctl tw_ctl_i(.clk(clk), .nrst(nrst), .link(tw_if_i), .req(req), .nbytes(nbytes),
      .wdata(wdata), .rd_mode(rd_mode), .wnext(wnext), .rdata(rdata), .rvalid(rvalid),
      .nack(nack), .done(done));
   tw_chk #(.PROG_CYC(PROG)) tw_chk_i(.clk(clk), .nrst(nrst), .scl(tw_if_i.scl),
      .sda(tw_if_i.sda), .sda_ctl_o(tw_if_i.sda_ctl_o), .sda_ctl_oe(tw_if_i.sda_ctl_oe),
      .sda_dev_o(tw_if_i.sda_dev_o), .sda_dev_oe(tw_if_i.sda_dev_oe));
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      if (mismatches == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // One transfer; the model learns written bytes only when accepted
   task automatic run(input logic rd, input logic [6:0] a, input int n, output logic got);
      logic [7:0] q[$];
      int k;
      int r;
      int i;
      q = {};
      for (k = 0; k < n; k++) begin
         rng_q = xs(rng_q);
         q.push_back(rng_q[7:0]);
      end
      k = 0;
      r = 0;
      @(posedge clk);
      req <= 1'b1;
      rd_mode <= rd;
      nbytes <= n[3:0];
      wdata <= {a, rd};
      for (i = 0; i < 20000; i++) begin
         @(posedge clk);
         req <= 1'b0;
         if (wnext) begin
            wdata <= (k < n) ? q[k] : 8'h00;
            k++;
         end
         if (rvalid) begin
            if (!$isunknown(mem[(a + r) % 128]))
               check(rdata, mem[(a + r) % 128]);
            r++;
         end
         if (done)
            break;
      end
      if (i == 20000) begin
         mismatches++;
         end_sim();
      end
      got = nack;
      if (rd && !got)
         check(r[7:0], n[7:0]);
      if (!rd && !got) begin
         for (k = 0; k < n; k++)
            mem[(a & 124) | ((a + k) & 3)] = q[k];
      end
   endtask
   // Repeats a refused request, as acknowledge polling does
   task automatic op(input logic rd, input logic [6:0] a, input int n, input logic busy_exp);
      logic got;
      int t;
      run(rd, a, n, got);
      check(got, busy_exp);
      for (t = 0; t < 12 && got; t++)
         run(rd, a, n, got);
      if (got) begin
         mismatches++;
         end_sim();
      end
   endtask
   // ****************************************
   // Stimulus
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      nrst = 1'b0;
      req = 1'b0;
      nbytes = 4'h0;
      wdata = 8'h00;
      rd_mode = 1'b0;
      rng_q = 32'ha5161a8c;
      mismatches = 0;
      samples_checked = 0;
      repeat (10) @(posedge clk);
      check(standby, 1'b1);
      check(busy, 1'b0);
      nrst <= 1'b1;
      op(1'b0, 7'h00, 4, 1'b0);
      op(1'b1, 7'h00, 4, 1'b1);
      op(1'b0, 7'h7e, 6, 1'b0);
      op(1'b1, 7'h7c, 6, 1'b1);
      for (j = 0; j < 4; j++) begin
         rng_q = xs(rng_q);
         ra = rng_q[6:0];
         rn = (j == 0) ? 1 : 1 + int'(rng_q[9:8]);
         op(1'b0, ra, rn, 1'b0);
         op(1'b1, ra, rn, 1'b1);
      end
      repeat (10) @(posedge clk);
      check(standby, 1'b1);
      end_sim();
   end
endmodule
